// File: pfd_pkg.sv
package pfd_pkg;
	// channel indices: both inputs get identical sync and halving; their frequency overrides force opposite levels
	localparam int CH_REF = 0;
	localparam int CH_FB = 1;
	localparam int NUM_CH = 2;

	// reset values
	localparam logic HALF_RST = 1'h0;
	localparam logic DISC_RST = 1'h1;
	localparam logic PEND_RST = 1'h0;
	localparam logic SYNC_RST = 1'h0;
	localparam logic OUT_RST = 1'h0;

	// level forced on the true output by each frequency override
	localparam logic SLOW_LEVEL = 1'h1;
	localparam logic FAST_LEVEL = 1'h0;

	// active level of a discriminator flip-flop that overrides the phase result
	localparam logic DISC_ACTIVE = 1'h0;
	localparam logic DISC_IDLE = 1'h1;

	// clock figures
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SYNC_LATENCY = 2;
endpackage

// File: phase_frequency_detector.sv
`timescale 1ns/1ps
module phase_frequency_detector (
	// clock, reset, enable
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// pulse inputs
	input wire logic ref_in,
	input wire logic feedback_in,
	// detector result
	output logic det_out,
	output logic det_out_n
);
	import pfd_pkg::*;

	logic [NUM_CH-1:0] in_vec;
	logic [NUM_CH-1:0] sync1_q;
	logic [NUM_CH-1:0] sync2_q;
	logic [NUM_CH-1:0] prev_q;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] half_q;
	logic [NUM_CH-1:0] pend_q;
	logic slow_ok_q;
	logic fast_ok_q;
	logic phase_xor;
	logic out_d;
	logic out_q;

	assign in_vec[CH_REF] = ref_in;
	assign in_vec[CH_FB] = feedback_in;

	// one identical channel per input; swapping the inputs only swaps the override sides
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// first stage feeds only the second, to keep metastability contained
			always_ff @(posedge clk) begin
				if (srst) begin
					sync1_q[g] <= SYNC_RST;
					sync2_q[g] <= SYNC_RST;
					prev_q[g] <= SYNC_RST;
				end else if (ce) begin
					sync1_q[g] <= in_vec[g];
					sync2_q[g] <= sync1_q[g];
					prev_q[g] <= sync2_q[g];
				end
			end

			assign rise[g] = sync2_q[g] & ~prev_q[g];

			always_ff @(posedge clk) begin
				if (srst) begin
					half_q[g] <= HALF_RST;
				end else if (ce && rise[g]) begin
					half_q[g] <= ~half_q[g];
				end
			end
		end
	endgenerate

	// pending marks: an edge on one input not yet answered by the other
	// simultaneous edges cancel, so neither side counts a double edge
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_q <= {NUM_CH{PEND_RST}};
		end else if (ce) begin
			if (rise[CH_REF] && rise[CH_FB]) begin
				pend_q <= {NUM_CH{PEND_RST}};
			end else if (rise[CH_REF]) begin
				pend_q[CH_REF] <= 1'h1;
				pend_q[CH_FB] <= PEND_RST;
			end else if (rise[CH_FB]) begin
				pend_q[CH_FB] <= 1'h1;
				pend_q[CH_REF] <= PEND_RST;
			end
		end
	end

	// slow side: two reference edges before a feedback edge
	always_ff @(posedge clk) begin
		if (srst) begin
			slow_ok_q <= DISC_RST;
		end else if (ce) begin
			if (rise[CH_FB]) begin
				slow_ok_q <= DISC_IDLE;
			end else if (rise[CH_REF] && pend_q[CH_REF]) begin
				slow_ok_q <= DISC_ACTIVE;
			end
		end
	end

	// fast side: two feedback edges before a reference edge
	always_ff @(posedge clk) begin
		if (srst) begin
			fast_ok_q <= DISC_RST;
		end else if (ce) begin
			if (rise[CH_REF]) begin
				fast_ok_q <= DISC_IDLE;
			end else if (rise[CH_FB] && pend_q[CH_FB]) begin
				fast_ok_q <= DISC_ACTIVE;
			end
		end
	end

	assign phase_xor = half_q[CH_REF] ^ half_q[CH_FB];

	// output gating; both sides cannot be active at once since each releases the other
	always_comb begin
		if (slow_ok_q == DISC_ACTIVE) begin
			out_d = SLOW_LEVEL;
		end else if (fast_ok_q == DISC_ACTIVE) begin
			out_d = FAST_LEVEL;
		end else begin
			out_d = phase_xor;
		end
	end

	// registered output costs one cycle but keeps glitches off the loop filter
	always_ff @(posedge clk) begin
		if (srst) begin
			out_q <= OUT_RST;
		end else if (ce) begin
			out_q <= out_d;
		end
	end

	assign det_out = out_q;
	assign det_out_n = ~out_q;

	sequence s_ref_double;
		ce && rise[CH_REF] && !rise[CH_FB] && pend_q[CH_REF];
	endsequence

	sequence s_fb_double;
		ce && rise[CH_FB] && !rise[CH_REF] && pend_q[CH_FB];
	endsequence

	property p_sync_delay;
		@(posedge clk) disable iff (srst)
		$past(ce) && $past(ce, 2) && !$past(srst) && !$past(srst, 2) |-> sync2_q == $past(in_vec, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("synchronizer latency wrong");

	property p_half_toggle;
		@(posedge clk) disable iff (srst)
		ce && rise[CH_REF] |=> half_q[CH_REF] != $past(half_q[CH_REF]);
	endproperty
	a_half_toggle: assert property (p_half_toggle) else $error("reference halving flop did not toggle");

	property p_half_hold;
		@(posedge clk) disable iff (srst)
		!(ce && rise[CH_FB]) |=> $stable(half_q[CH_FB]);
	endproperty
	a_half_hold: assert property (p_half_hold) else $error("feedback halving flop moved without an edge");

	property p_phase_pass;
		@(posedge clk) disable iff (srst)
		ce && slow_ok_q && fast_ok_q |=> det_out == $past(phase_xor);
	endproperty
	a_phase_pass: assert property (p_phase_pass) else $error("xor result not passed near lock");

	property p_slow_set;
		@(posedge clk) disable iff (srst)
		s_ref_double ##1 ce |-> slow_ok_q == DISC_ACTIVE ##1 det_out == SLOW_LEVEL;
	endproperty
	a_slow_set: assert property (p_slow_set) else $error("slow override missed double reference edge");

	property p_fast_set;
		@(posedge clk) disable iff (srst)
		s_fb_double ##1 ce |=> det_out == FAST_LEVEL;
	endproperty
	a_fast_set: assert property (p_fast_set) else $error("fast override did not hold output low");

	property p_release;
		@(posedge clk) disable iff (srst)
		ce && rise[CH_FB] |=> slow_ok_q == DISC_IDLE;
	endproperty
	a_release: assert property (p_release) else $error("feedback edge did not release slow override");

	property p_exclusive;
		@(posedge clk) disable iff (srst)
		!(slow_ok_q == DISC_ACTIVE && fast_ok_q == DISC_ACTIVE);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("both overrides active");

	property p_complement;
		@(posedge clk) det_out_n == !det_out;
	endproperty
	a_complement: assert property (p_complement) else $error("outputs not complementary");

	property p_reset;
		@(posedge clk) srst |=> half_q == {NUM_CH{HALF_RST}} && slow_ok_q && fast_ok_q && !det_out;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	property p_fb_toggle;
		@(posedge clk) disable iff (srst)
		ce && rise[CH_FB] |=> half_q[CH_FB] != $past(half_q[CH_FB]);
	endproperty
	a_fb_toggle: assert property (p_fb_toggle) else $error("feedback halving flop did not toggle");

	property p_ref_hold;
		@(posedge clk) disable iff (srst)
		!(ce && rise[CH_REF]) |=> $stable(half_q[CH_REF]);
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("reference halving flop moved without an edge");

	property p_fast_release;
		@(posedge clk) disable iff (srst)
		ce && rise[CH_REF] |=> fast_ok_q == DISC_IDLE;
	endproperty
	a_fast_release: assert property (p_fast_release) else $error("reference edge did not release fast override");

	// an override must keep steering for as long as it stands, not just on its first cycle
	property p_slow_hold;
		@(posedge clk) disable iff (srst)
		ce && slow_ok_q == DISC_ACTIVE |=> det_out == SLOW_LEVEL;
	endproperty
	a_slow_hold: assert property (p_slow_hold) else $error("slow override not holding output");

	property p_fast_hold;
		@(posedge clk) disable iff (srst)
		ce && fast_ok_q == DISC_ACTIVE |=> det_out == FAST_LEVEL;
	endproperty
	a_fast_hold: assert property (p_fast_hold) else $error("fast override not holding output");

	// a low enable must freeze the whole pipeline, or edges would be counted twice
	property p_freeze;
		@(posedge clk) disable iff (srst)
		!ce |=> $stable(det_out) && $stable(half_q) && $stable(sync2_q) && $stable(slow_ok_q) && $stable(fast_ok_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while enable low");
endmodule

// File: pulse_src.sv
`timescale 1ns/1ps
module pulse_src (
	// clock
	input wire logic clk,
	// shape
	input wire logic en,
	input wire integer period,
	input wire integer high,
	// pulse train
	output logic pulse
);
	int cnt = 0;
	initial pulse = 1'h0;
	// idle low while stopped; high and low phases kept at two clocks or more
	always @(negedge clk) begin
		if (!en) begin
			cnt <= 0;
			pulse <= 1'h0;
		end else begin
			cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
			pulse <= (cnt < high);
		end
	end
endmodule

// File: phase_frequency_detector_test.sv
`timescale 1ns/1ps
module phase_frequency_detector_test;
	import pfd_pkg::*;
	logic clk, srst, ce, ref_in, feedback_in, det_out, det_out_n, en_r, en_f, armed, rce;
	logic [1:0] s1, s2, s3;
	logic hr, hf, pr, pf, slow, fast, m_out, rr, rf;
	int per_r, per_f, fail_count, tests_run, seed, i;
	phase_frequency_detector dut_u (.clk(clk), .srst(srst), .ce(ce), .ref_in(ref_in),
		.feedback_in(feedback_in), .det_out(det_out), .det_out_n(det_out_n));
	pulse_src src_r (.clk(clk), .en(en_r), .period(per_r), .high(per_r / 2), .pulse(ref_in));
	pulse_src src_f (.clk(clk), .en(en_f), .period(per_f), .high(per_f / 2), .pulse(feedback_in));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// reference model: two sync stages, one state stage, one output stage
	always @(posedge clk) begin
		if (srst) begin
			{s1, s2, s3} = {6{SYNC_RST}};
			{hr, hf, pr, pf} = {HALF_RST, HALF_RST, PEND_RST, PEND_RST};
			{slow, fast, m_out} = {DISC_RST, DISC_RST, OUT_RST};
		end else if (ce) begin
			m_out = (slow === DISC_ACTIVE) ? SLOW_LEVEL : (fast === DISC_ACTIVE) ? FAST_LEVEL : hr ^ hf;
			rr = s2[0] & ~s3[0];
			rf = s2[1] & ~s3[1];
			hr = hr ^ rr;
			hf = hf ^ rf;
			if (rr && rf) {pr, pf, slow, fast} = {PEND_RST, PEND_RST, DISC_IDLE, DISC_IDLE};
			else if (rr) begin
				if (pr) slow = DISC_ACTIVE;
				{pr, pf, fast} = {1'h1, PEND_RST, DISC_IDLE};
			end else if (rf) begin
				if (pf) fast = DISC_ACTIVE;
				{pf, pr, slow} = {1'h1, PEND_RST, DISC_IDLE};
			end
			s3 = s2;
			s2 = s1;
			s1 = {feedback_in, ref_in};
		end
	end
	task check_out();
		tests_run++;
		if (det_out !== m_out || det_out_n !== ~m_out) begin
			fail_count++;
			$display("wrong value at %0t: det_out %b det_out_n %b model %b", $time, det_out, det_out_n, m_out);
		end
	endtask
	always @(negedge clk) if (armed) check_out();
	task give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// restart both sources with a start offset of dly clocks
	task run(input int a, input int b, input int dly, input int n);
		{en_r, en_f, per_r, per_f} = {2'h0, a, b};
		repeat (4) @(negedge clk);
		en_r = 1'h1;
		repeat (dly) @(negedge clk);
		en_f = 1'h1;
		repeat (n) begin
			@(negedge clk);
			ce = rce ? ({$random(seed)} % 4 != 0) : 1'h1;
		end
	endtask
	initial begin
		{srst, ce, en_r, en_f, armed, rce} = 6'h32;
		{fail_count, tests_run, per_r, per_f} = {32'h0, 32'h0, 32'hA, 32'hA};
		seed = 32'h21e8712a;
		repeat (2) @(negedge clk);
		srst = 1'h0;
		armed = 1'h1;
		run(20, 20, 10, 400);
		run(20, 20, 3, 400);
		run(20, 20, 0, 200);
		run(12, 30, 5, 600);
		run(30, 12, 5, 600);
		per_r = 20;
		per_f = 20;
		repeat (400) @(negedge clk);
		srst = 1'h1;
		@(negedge clk);
		srst = 1'h0;
		for (i = 0; i < 24; i++) begin
			rce = i[0];
			run(4 + {$random(seed)} % 40, 4 + {$random(seed)} % 40, {$random(seed)} % 20, 300);
		end
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
endmodule
